// ==== rtl/mats_pkg.sv ====
// Constants, register map and field layouts of the meter command block
// Assumes an APB master on mclk and an acquisition front end on mclk
//
// What this block does
// - Run control: 0 halts, 1 runs acquisition
// - Run query returns 0 stopped, 1 running
// - Responsivity query returns applied conversion factor
// - Writable spot size, defaults to detector area
// - Spot size query returns held value
// - Maximum query returns largest buffered reading
// - Mean query returns average of buffered readings
// - Minimum query returns smallest buffered reading
// - Spread query returns maximum minus minimum
// - Deviation query returns standard deviation of readings
// - Temperature query returns detector temperature
// - Trigger enable codes: off, A, B, both
// - Trigger enable query returns stored code
// - Edge select: 0 falling, 1 rising
// - Edge query returns 0 falling, 1 rising
package mats_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam logic [AW-1:0] ADDR_RUN     = 8'h00;
   localparam logic [AW-1:0] ADDR_RESP    = 8'h04;
   localparam logic [AW-1:0] ADDR_SPOT    = 8'h08;
   localparam logic [AW-1:0] ADDR_MAX     = 8'h0c;
   localparam logic [AW-1:0] ADDR_MEAN    = 8'h10;
   localparam logic [AW-1:0] ADDR_MIN     = 8'h14;
   localparam logic [AW-1:0] ADDR_SPREAD  = 8'h18;
   localparam logic [AW-1:0] ADDR_SDEV    = 8'h1c;
   localparam logic [AW-1:0] ADDR_TEMP    = 8'h20;
   localparam logic [AW-1:0] ADDR_TRIGEN  = 8'h24;
   localparam logic [AW-1:0] ADDR_EDGE    = 8'h28;
   localparam logic [AW-1:0] ADDR_COUNT   = 8'h2c;
   localparam logic [AW-1:0] ADDR_CLEAR   = 8'h30;
   localparam logic [DW-1:0] FLOAT_ZERO   = 32'h0000_0000;
   localparam int TRIG_A_BIT = 0;
   localparam int TRIG_B_BIT = 1;
   localparam logic [1:0] TRIG_OFF = 2'h0;
   localparam logic       EDGE_FALL = 1'h0;
   localparam logic       EDGE_RISE = 1'h1;
   localparam logic [5:0] SQRT_STEPS = 6'h20;
   localparam int CNT_W = 16;
endpackage : mats_pkg

// ==== rtl/mats_edge_det.sv ====
// Two-stage synchroniser and selectable edge detector for a trigger pin
// Assumes an asynchronous pin and one enable per channel
module mats_edge_det (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic pinIn,
   input  wire logic risingSel,
   input  wire logic enable,
   output logic      trigPulse
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;
   wire  rise = sync2_r & ~prev_r;
   wire  fall = ~sync2_r & prev_r;
   wire  hit = enable & (risingSel ? rise : fall);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_r   <= 1'b0;
         sync2_r   <= 1'b0;
         prev_r    <= 1'b0;
         trigPulse <= 1'b0;
      end else begin
         sync1_r   <= pinIn;
         sync2_r   <= sync1_r;
         prev_r    <= sync2_r;
         trigPulse <= hit;
      end
   end
endmodule : mats_edge_det

// ==== rtl/mats_isqrt.sv ====
// Sequential integer square root, one result bit per cycle
// Assumes start is a one-cycle pulse while idle
module mats_isqrt (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [63:0] radicand,
   output logic [31:0]      root,
   output logic             busy
);
   logic [63:0] rem_r;
   logic [31:0] res_r;
   logic [5:0]  step_r;
   wire  [31:0] trial  = res_r | (32'h8000_0000 >> step_r);
   wire  [63:0] trialSq = trial * trial;
   wire         fits   = trialSq <= rem_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rem_r  <= '0;
         res_r  <= '0;
         step_r <= '0;
         busy   <= 1'b0;
         root   <= '0;
      end else if (start && !busy) begin
         rem_r  <= radicand;
         res_r  <= '0;
         step_r <= '0;
         busy   <= 1'b1;
      end else if (busy) begin
         if (fits)
            res_r <= trial;
         if (step_r == mats_pkg::SQRT_STEPS - 6'h1) begin
            busy <= 1'b0;
            root <= fits ? trial : res_r;
         end
         step_r <= step_r + 6'h1;
      end
   end
endmodule : mats_isqrt

// ==== rtl/mats_top.sv ====
// Meter acquisition, trigger and statistics command block with APB slave
// Assumes readings arrive as signed 32-bit integers on mclk, and that the
// responsivity, detector area and temperature words come from the front end
module mats_top (
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [mats_pkg::AW-1:0]  paddr,
   input  wire logic [mats_pkg::DW-1:0]  pwdata,
   output logic      [mats_pkg::DW-1:0]  prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     sampleValid,
   input  wire logic signed [31:0]       sampleData,
   input  wire logic [mats_pkg::DW-1:0]  respFactor,
   input  wire logic [mats_pkg::DW-1:0]  detectorArea,
   input  wire logic [mats_pkg::DW-1:0]  detectorTemp,
   input  wire logic                     extTrigPin,
   output logic                          acqRun,
   output logic                          trigA,
   output logic                          trigB
);
   logic                     run_r;
   logic [mats_pkg::DW-1:0]  spot_r;
   logic                     spotLoaded_r;
   logic [1:0]               trigEn_r;
   logic                     edge_r;
   logic signed [31:0]       max_r;
   logic signed [31:0]       min_r;
   logic signed [47:0]       sum_r;
   logic [79:0]              sumSq_r;
   logic [mats_pkg::CNT_W-1:0] cnt_r;
   logic                     sqrtStart_r;
   logic [31:0]              sdevRoot;
   logic                     sqrtBusy;
   logic                     trigPulseA;
   logic                     trigPulseB;
   logic                     sqrtDirty_r;

   // All checks below run on mclk and sleep while reset is low
   default clocking ck @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   // APB decode: one wait-free access phase
   wire acc   = psel & penable;
   wire wrAcc = acc & pwrite;
   wire rdAcc = acc & ~pwrite;
   wire hitRun   = paddr == mats_pkg::ADDR_RUN;
   wire hitSpot  = paddr == mats_pkg::ADDR_SPOT;
   wire hitTrig  = paddr == mats_pkg::ADDR_TRIGEN;
   wire hitEdge  = paddr == mats_pkg::ADDR_EDGE;
   wire hitClear = paddr == mats_pkg::ADDR_CLEAR;
   wire hitRo = paddr == mats_pkg::ADDR_RESP  || paddr == mats_pkg::ADDR_MAX
             || paddr == mats_pkg::ADDR_MEAN  || paddr == mats_pkg::ADDR_MIN
             || paddr == mats_pkg::ADDR_SPREAD|| paddr == mats_pkg::ADDR_SDEV
             || paddr == mats_pkg::ADDR_TEMP  || paddr == mats_pkg::ADDR_COUNT;
   wire hitRw = hitRun | hitSpot | hitTrig | hitEdge;
   wire mapped = pwrite ? (hitRw | hitClear) : (hitRw | hitRo);

   // Statistics arithmetic
   wire empty = cnt_r == '0;
   wire take  = sampleValid & run_r;
   wire signed [63:0] sampSq = sampleData * sampleData;
   wire signed [47:0] meanW = empty ? 48'sd0 :
      sum_r / $signed({32'h0, cnt_r});
   wire signed [31:0] meanV = meanW[31:0];
   wire [79:0] meanSqW = empty ? 80'h0 : sumSq_r / {64'h0, cnt_r};
   wire [63:0] meanSq  = meanSqW[63:0];
   wire signed [63:0] sqMean = meanV * meanV;
   wire [63:0] varV = (meanSq > sqMean) ? meanSq - sqMean : 64'h0;
   wire signed [31:0] spreadV = max_r - min_r;

   wire [31:0] statMax  = empty ? mats_pkg::FLOAT_ZERO : max_r;
   wire [31:0] statMin  = empty ? mats_pkg::FLOAT_ZERO : min_r;
   wire [31:0] statMean = empty ? mats_pkg::FLOAT_ZERO : meanV;
   wire [31:0] statSprd = empty ? mats_pkg::FLOAT_ZERO : spreadV;
   wire [31:0] statSdev = empty ? mats_pkg::FLOAT_ZERO : sdevRoot;

   logic [31:0] rdMux;
   always_comb begin
      rdMux = '0;
      case (paddr)
         mats_pkg::ADDR_RUN:    rdMux = {31'h0, run_r};
         mats_pkg::ADDR_RESP:   rdMux = respFactor;
         mats_pkg::ADDR_SPOT:   rdMux = spot_r;
         mats_pkg::ADDR_MAX:    rdMux = statMax;
         mats_pkg::ADDR_MEAN:   rdMux = statMean;
         mats_pkg::ADDR_MIN:    rdMux = statMin;
         mats_pkg::ADDR_SPREAD: rdMux = statSprd;
         mats_pkg::ADDR_SDEV:   rdMux = statSdev;
         mats_pkg::ADDR_TEMP:   rdMux = detectorTemp;
         mats_pkg::ADDR_TRIGEN: rdMux = {30'h0, trigEn_r};
         mats_pkg::ADDR_EDGE:   rdMux = {31'h0, edge_r};
         mats_pkg::ADDR_COUNT:  rdMux = {16'h0, cnt_r};
         default:               rdMux = '0;
      endcase
   end

   // APB outputs: ready in the access phase, registered
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= (psel & ~penable & ~pwrite) ? rdMux : '0;
      end
   end

   wire wrDone = wrAcc & pready;

   // Control registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_r        <= 1'b0;
         spot_r       <= '0;
         spotLoaded_r <= 1'b0;
         trigEn_r     <= mats_pkg::TRIG_OFF;
         edge_r       <= mats_pkg::EDGE_FALL;
      end else begin
         if (wrDone && hitRun)
            run_r <= pwdata[0];
         if (!spotLoaded_r) begin
            spot_r       <= detectorArea;
            spotLoaded_r <= 1'b1;
         end else if (wrDone && hitSpot)
            spot_r <= pwdata;
         if (wrDone && hitTrig)
            trigEn_r <= pwdata[1:0];
         if (wrDone && hitEdge)
            edge_r <= pwdata[0];
      end
   end

   // Statistics buffer accumulation
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         max_r   <= '0;
         min_r   <= '0;
         sum_r   <= '0;
         sumSq_r <= '0;
         cnt_r   <= '0;
      end else if (wrDone && hitClear) begin
         cnt_r   <= '0;
         sum_r   <= '0;
         sumSq_r <= '0;
      end else if (take && cnt_r != '1) begin
         cnt_r   <= cnt_r + 1'b1;
         sum_r   <= sum_r + 48'(sampleData);
         sumSq_r <= sumSq_r + 80'(sampSq);
         if (empty || sampleData > max_r)
            max_r <= sampleData;
         if (empty || sampleData < min_r)
            min_r <= sampleData;
      end
   end

   // recompute after each reading taken
   // Readings that land while the root is busy leave the flag set, so the
   // deviation always catches up with the last reading
   wire sqrtIssue = sqrtDirty_r & ~sqrtBusy & ~sqrtStart_r;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sqrtStart_r <= 1'b0;
         sqrtDirty_r <= 1'b0;
      end else begin
         sqrtStart_r <= sqrtIssue;
         if (take)
            sqrtDirty_r <= 1'b1;
         else if (sqrtIssue)
            sqrtDirty_r <= 1'b0;
      end
   end

   mats_isqrt u_sqrt (
      .mclk     (mclk),
      .resetn   (resetn),
      .start    (sqrtStart_r),
      .radicand (varV),
      .root     (sdevRoot),
      .busy     (sqrtBusy)
   );

   mats_edge_det u_trigA (
      .mclk      (mclk),
      .resetn    (resetn),
      .pinIn     (extTrigPin),
      .risingSel (edge_r),
      .enable    (trigEn_r[mats_pkg::TRIG_A_BIT]),
      .trigPulse (trigPulseA)
   );

   mats_edge_det u_trigB (
      .mclk      (mclk),
      .resetn    (resetn),
      .pinIn     (extTrigPin),
      .risingSel (edge_r),
      .enable    (trigEn_r[mats_pkg::TRIG_B_BIT]),
      .trigPulse (trigPulseB)
   );

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acqRun <= 1'b0;
         trigA  <= 1'b0;
         trigB  <= 1'b0;
      end else begin
         acqRun <= run_r;
         trigA  <= trigPulseA;
         trigB  <= trigPulseB;
      end
   end

   // Read setup cycle for one address, answered at the next edge
   sequence s_rd_setup(logic [mats_pkg::AW-1:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   a_run_write: assert property (
      wrDone && hitRun |=> run_r == $past(pwdata[0]))
      else $error("run bit did not follow write");
   a_run_out: assert property (
      acqRun == $past(run_r))
      else $error("acqRun does not mirror run state");
   a_run_read: assert property (
      s_rd_setup(mats_pkg::ADDR_RUN) |=> prdata == {31'h0, $past(run_r)})
      else $error("run state read back wrong");
   a_resp_read: assert property (
      s_rd_setup(mats_pkg::ADDR_RESP) |=> prdata == $past(respFactor))
      else $error("conversion factor read back wrong");
   a_spot_write: assert property (
      spotLoaded_r && wrDone && hitSpot |=> spot_r == $past(pwdata))
      else $error("beam area not stored");
   a_spot_read: assert property (
      s_rd_setup(mats_pkg::ADDR_SPOT) |=> prdata == $past(spot_r))
      else $error("beam area read back wrong");
   a_temp_read: assert property (
      s_rd_setup(mats_pkg::ADDR_TEMP) |=> prdata == $past(detectorTemp))
      else $error("temperature read back wrong");
   a_trig_code: assert property (
      wrDone && hitTrig |=> trigEn_r == $past(pwdata[1:0]))
      else $error("trigger enable code not stored");
   a_trig_read: assert property (
      s_rd_setup(mats_pkg::ADDR_TRIGEN)
         |=> prdata == {30'h0, $past(trigEn_r)})
      else $error("trigger enable code read back wrong");
   a_trig_off: assert property (
      trigEn_r == mats_pkg::TRIG_OFF [*3] |=> !trigA && !trigB)
      else $error("trigger fired while disabled");
   a_edge_store: assert property (
      wrDone && hitEdge |=> edge_r == $past(pwdata[0]))
      else $error("edge select not stored");
   a_edge_read: assert property (
      s_rd_setup(mats_pkg::ADDR_EDGE) |=> prdata == {31'h0, $past(edge_r)})
      else $error("edge select read back wrong");
   a_empty_zero: assert property (
      empty |-> statMax == '0 && statMin == '0 && statMean == '0
         && statSprd == '0 && statSdev == '0)
      else $error("statistic nonzero on empty buffer");
   a_clear_empty: assert property (
      wrDone && hitClear |=> empty)
      else $error("clear left readings in the buffer");
   a_spread_rel: assert property (
      !empty |-> statSprd == max_r - min_r && max_r >= min_r)
      else $error("spread inconsistent");
   a_max_track: assert property (
      take && !(wrDone && hitClear) && cnt_r != '1
         |=> max_r >= $past(sampleData))
      else $error("maximum below new reading");
   a_min_track: assert property (
      take && !(wrDone && hitClear) && cnt_r != '1
         |=> min_r <= $past(sampleData))
      else $error("minimum above new reading");
   a_sdev_start: assert property (
      take |-> ##[1:40] sqrtStart_r)
      else $error("deviation not recomputed after reading");
endmodule : mats_top

// ==== verification/mats_host.sv ====
// Host controller model: an APB master issuing single register transfers
// Assumes mclk from the bench and a zero or more wait state APB slave
module mats_host (
   input  wire logic        mclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   logic tmo;

   initial begin
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      tmo     = 1'h0;
   end

   // Request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
      int i;
      @(posedge mclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'h1) break;
      end
      if (i == 20) tmo = 1'h1;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : xfer
endmodule : mats_host

// ==== verification/meter_acquisition_trigger_stats_test.sv ====
// Self-checking bench for the meter command block, queue-based stats model
// Assumes mats_top with an APB slave and the mats_host master model
module meter_acquisition_trigger_stats_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic               mclk = 1'h0;
   logic               resetn = 1'h0;
   logic               psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata;
   logic               sampleValid = 1'h0;
   logic signed [31:0] sampleData = 32'sh0;
   logic [31:0]        respFactor, detectorArea, detectorTemp;
   logic               extTrigPin = 1'h0;
   logic               acqRun, trigA, trigB;
   int                 nFail = 0;
   int                 checksDone = 0;
   longint             q[$];

   always #5 mclk = ~mclk;

   mats_top uut (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sampleValid(sampleValid), .sampleData(sampleData),
      .respFactor(respFactor), .detectorArea(detectorArea),
      .detectorTemp(detectorTemp), .extTrigPin(extTrigPin),
      .acqRun(acqRun), .trigA(trigA), .trigB(trigB));

   mats_host host (.mclk(mclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   task automatic results;
      if (host.tmo === 1'h1) nFail++;
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic regRead(input logic [7:0] a, input logic [31:0] e,
                          input string nm, input logic eErr = 1'h0);
      logic [31:0] v;
      logic        er;
      host.xfer(1'h0, a, 32'h0, v, er);
      if (host.tmo === 1'h1) results();
      chk(nm, e, v);
      chk({nm, " slverr"}, {31'h0, eErr}, {31'h0, er});
   endtask : regRead

   task automatic regWrite(input logic [7:0] a, input logic [31:0] d,
                           input logic eErr = 1'h0);
      logic [31:0] v;
      logic        er;
      host.xfer(1'h1, a, d, v, er);
      if (host.tmo === 1'h1) results();
      chk("write slverr", {31'h0, eErr}, {31'h0, er});
   endtask : regWrite

   task automatic sendSample(input longint v);
      @(posedge mclk);
      sampleValid <= 1'h1;
      sampleData  <= 32'(v);
      @(posedge mclk);
      sampleValid <= 1'h0;
   endtask : sendSample

   function automatic longint isq(input longint v);
      longint r = 0;
      while ((r + 1) * (r + 1) <= v) r++;
      return r;
   endfunction : isq

   task automatic statsChk;
      longint s, v, mx, mn, m, n;
      n = q.size();
      s = 0; v = 0; mx = 0; mn = 0; m = 0;
      foreach (q[j]) begin
         s += q[j];
         if (j == 0 || q[j] > mx) mx = q[j];
         if (j == 0 || q[j] < mn) mn = q[j];
      end
      if (n > 0) m = s / n;
      foreach (q[j]) v += (q[j] - m) * (q[j] - m);
      if (n > 0) v = v / n;
      regRead(mats_pkg::ADDR_COUNT, 32'(n), "count");
      regRead(mats_pkg::ADDR_MAX, 32'(mx), "max");
      regRead(mats_pkg::ADDR_MIN, 32'(mn), "min");
      regRead(mats_pkg::ADDR_MEAN, 32'(m), "mean");
      regRead(mats_pkg::ADDR_SPREAD, 32'(mx - mn), "spread");
      regRead(mats_pkg::ADDR_SDEV, 32'(isq(v)), "sdev");
   endtask : statsChk

   // Counts trigger pulses over the twelve edges after a pin change
   task automatic countTrig(output int a, output int b);
      a = 0;
      b = 0;
      repeat (12) begin
         @(posedge mclk);
         #1;
         a += int'(trigA === 1'h1);
         b += int'(trigB === 1'h1);
      end
   endtask : countTrig

   initial begin
      int c, e, na, nb, b, d, k;
      logic [31:0] sp;
      void'($urandom(92492));
      @(posedge mclk);
      respFactor   <= $urandom;
      detectorArea <= $urandom;
      detectorTemp <= $urandom;
      repeat (5) @(posedge mclk);
      resetn <= 1'h1;
      // Power-up values, read-only words and refusals
      regRead(mats_pkg::ADDR_RUN, 32'h0, "run");
      regRead(mats_pkg::ADDR_RESP, respFactor, "resp");
      regRead(mats_pkg::ADDR_SPOT, detectorArea, "spot");
      regRead(mats_pkg::ADDR_TEMP, detectorTemp, "temp");
      regRead(mats_pkg::ADDR_TRIGEN, 32'h0, "trigEn");
      regRead(mats_pkg::ADDR_EDGE, 32'h0, "edge");
      regWrite(mats_pkg::ADDR_RESP, 32'h5a, 1'h1);
      regRead(mats_pkg::ADDR_RESP, respFactor, "resp kept");
      regRead(8'h40, 32'h0, "unmapped", 1'h1);
      sendSample(77);
      statsChk();
      $display("test power-up done");
      // Run control and spot size
      regWrite(mats_pkg::ADDR_RUN, 32'h1);
      regRead(mats_pkg::ADDR_RUN, 32'h1, "run");
      repeat (2) @(posedge mclk);
      chk("acqRun", 32'h1, {31'h0, acqRun});
      sp = $urandom;
      regWrite(mats_pkg::ADDR_SPOT, sp);
      regRead(mats_pkg::ADDR_SPOT, sp, "spot");
      $display("test run and spot done");
      // Statistics over symmetric pairs, then clear
      b = int'($urandom_range(2000)) - 1000;
      d = int'($urandom_range(500));
      k = int'($urandom_range(6, 3));
      repeat (k) begin
         sendSample(b - d);
         q.push_back(b - d);
         sendSample(b + d);
         q.push_back(b + d);
      end
      repeat (80) @(posedge mclk);
      statsChk();
      regWrite(mats_pkg::ADDR_CLEAR, 32'h1);
      q.delete();
      statsChk();
      regWrite(mats_pkg::ADDR_RUN, 32'h0);
      regRead(mats_pkg::ADDR_RUN, 32'h0, "run");
      repeat (2) @(posedge mclk);
      chk("acqRun", 32'h0, {31'h0, acqRun});
      $display("test statistics done");
      // Every enable code against both edges; the other edge stays silent
      for (c = 0; c < 4; c++) begin
         for (e = 0; e < 2; e++) begin
            regWrite(mats_pkg::ADDR_TRIGEN, 32'(c));
            regWrite(mats_pkg::ADDR_EDGE, 32'(e));
            regRead(mats_pkg::ADDR_TRIGEN, 32'(c), "trigEn");
            regRead(mats_pkg::ADDR_EDGE, 32'(e), "edge");
            @(posedge mclk);
            extTrigPin <= ~e[0];
            countTrig(na, nb);
            chk("trig idle edge", 32'h0, 32'(na + nb));
            @(posedge mclk);
            extTrigPin <= e[0];
            countTrig(na, nb);
            chk("trigA", 32'(c & 1), 32'(na));
            chk("trigB", 32'(c >> 1), 32'(nb));
            @(posedge mclk);
            extTrigPin <= ~e[0];
            countTrig(na, nb);
            chk("trig wrong edge", 32'h0, 32'(na + nb));
         end
      end
      $display("test trigger done");
      results();
   end
endmodule : meter_acquisition_trigger_stats_test
